// ---- rtl/lpddr_pkg.sv ----
// Constants, types and enumerations of the LPDDR core interface.
// Assumes a single system clock of 200 MHz that oversamples every pin but the burst, latency and partial array settings.
package lpddr_pkg;

  localparam int DQ_W = 16;
  localparam int LANES = 2;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 13;
  localparam int AP_BIT = 10;
  localparam int BANK_W = 2;
  localparam int ROW_W = 2;
  localparam int COL_W = 4;
  localparam int BANKS = 4;
  localparam int MEM_AW = BANK_W + ROW_W + COL_W;
  localparam int MEM_DEPTH = 1 << MEM_AW;
  localparam int IDX_W = 5;
  localparam int PIN_W = 43;

  typedef logic [MEM_AW-1:0] mem_addr_t;

  // Self refresh interval in ns; the hot sensor reading halves it.
  localparam int CLK_PERIOD_NS = 5;
  localparam int SR_PERIOD_NS = 1000;
  localparam int SR_CNT_W = 8;
  localparam logic [SR_CNT_W-1:0] SR_PERIOD_CNT = SR_CNT_W'(SR_PERIOD_NS / CLK_PERIOD_NS);
  localparam logic [SR_CNT_W-1:0] SR_HOT_CNT = SR_CNT_W'(SR_PERIOD_NS / CLK_PERIOD_NS / 2);

  // Rising edges to wait after a read command before the first word.
  localparam logic READ_LATENCY_3 = 1'b1;
  localparam logic [1:0] RL2_WAIT = 2'h1;
  localparam logic [1:0] RL3_WAIT = 2'h2;

  localparam logic ORDER_INTERLEAVED = 1'b1;
  localparam logic [IDX_W-1:0] BL_BASE = 5'h2;
  localparam logic [IDX_W-1:0] PAIR_STEP = 5'h2;

  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE, CMD_BST, CMD_PRE, CMD_REF, CMD_LMR
  } cmd_e;

  typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_FIRST, RD_SECOND} rd_state_e;

  typedef enum logic [1:0] {PWR_ACTIVE, PWR_SELF_REFRESH, PWR_DEEP_DOWN} pwr_e;

endpackage

// ---- rtl/lpddr_core_interface.sv ----
// Core interface of a low-power DDR SDRAM: command decode, banks, bursts and array.
// Assumes pins come from the controller asynchronously; clock_i oversamples all but the burst, latency and partial array settings.
`timescale 1ns/10ps

module lpddr_core_interface (
  input wire logic clock_i, // System clock, 200 MHz.
  input wire logic sys_rst_i, // Asynchronous reset, active high.
  input wire logic true_clock_i, // Link clock, true phase.
  input wire logic complement_clock_i, // Link clock, complement phase.
  input wire logic cke_i, // Clock enable pin.
  input wire logic cs_n_i, // Chip select, active low.
  input wire logic ras_n_i, // Row strobe, active low.
  input wire logic cas_n_i, // Column strobe, active low.
  input wire logic we_n_i, // Write enable, active low.
  input wire logic bank_select_bit0_i, // Bank address bit 0.
  input wire logic bank_select_bit1_i, // Bank address bit 1.
  input wire logic [lpddr_pkg::ADDR_W-1:0] addr_i, // Address pins.
  input wire logic [lpddr_pkg::DQ_W-1:0] dq_i, // Data pins, input side.
  output logic [lpddr_pkg::DQ_W-1:0] dq_o, // Data pins, output side.
  output logic dq_oe_o, // Data pins driven.
  input wire logic [lpddr_pkg::LANES-1:0] dqs_i, // Strobes, input side.
  output logic [lpddr_pkg::LANES-1:0] dqs_o, // Strobes, output side.
  output logic [lpddr_pkg::LANES-1:0] dqs_oe_o, // Strobes driven.
  input wire logic [lpddr_pkg::LANES-1:0] write_byte_mask_i, // High skips the byte.
  input wire logic [1:0] burst_len_i, // 0..3 gives 2, 4, 8, 16 words.
  input wire logic burst_order_i, // High selects interleaved order.
  input wire logic read_latency_i, // Low latency two, high three.
  input wire logic [lpddr_pkg::BANKS-1:0] partial_array_self_refresh_i, // Banks kept.
  input wire logic temp_sensor_hot_i, // On-chip sensor reads hot.
  output logic [lpddr_pkg::BANKS-1:0] bank_open_o, // Bank has a row open.
  output logic self_refresh_o, // In self refresh.
  output logic deep_power_down_o, // In deep power-down.
  output logic refresh_pulse_o // One cycle per refresh performed.
);
  import lpddr_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and link clock edges.

  logic [PIN_W-1:0] pin_s1;
  logic [PIN_W-1:0] pin_s2;
  logic ck_hi_q;
  logic [LANES-1:0] dqs_q;
  wire s_hot, s_ck, s_ckn, s_cke, s_cs_n, s_ras_n, s_cas_n, s_we_n, s_ba1, s_ba0;
  wire [ADDR_W-1:0] s_addr;
  wire [DQ_W-1:0] s_dq;
  wire [LANES-1:0] s_dqs;
  wire [LANES-1:0] s_mask;

  assign {s_hot, s_ck, s_ckn, s_cke, s_cs_n, s_ras_n, s_cas_n, s_we_n, s_ba1, s_ba0,
          s_addr, s_dq, s_dqs, s_mask} = pin_s2;
  wire ck_hi = s_ck & ~s_ckn;

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      ck_hi_q <= 1'b0;
      dqs_q <= '0;
    end else begin
      pin_s1 <= {temp_sensor_hot_i, true_clock_i, complement_clock_i, cke_i, cs_n_i,
                 ras_n_i, cas_n_i, we_n_i, bank_select_bit1_i, bank_select_bit0_i,
                 addr_i, dq_i, dqs_i, write_byte_mask_i};
      pin_s2 <= pin_s1;
      ck_hi_q <= ck_hi;
      dqs_q <= s_dqs;
    end
  end

  wire rise = ck_hi & ~ck_hi_q;
  wire fall = ~ck_hi & ck_hi_q;
  wire [LANES-1:0] lane_rise = s_dqs & ~dqs_q;
  wire [LANES-1:0] lane_fall = ~s_dqs & dqs_q;

  //////////////////////////////////////////////////////////////////////////////
  // Command decode.

  pwr_e pwr;
  cmd_e cmd;
  assign cmd = s_ras_n ? (s_cas_n ? (s_we_n ? CMD_NOP : CMD_BST)
                                  : (s_we_n ? CMD_READ : CMD_WRITE))
                       : (s_cas_n ? (s_we_n ? CMD_ACT : CMD_PRE)
                                  : (s_we_n ? CMD_REF : CMD_LMR));

  wire sel = rise & (pwr == PWR_ACTIVE) & ~s_cs_n;
  wire take = sel & s_cke;
  wire [BANK_W-1:0] ba = {s_ba1, s_ba0};
  wire ap = s_addr[AP_BIT];
  wire go_act = take & (cmd == CMD_ACT);
  wire go_pre = take & (cmd == CMD_PRE);
  wire go_ref = take & (cmd == CMD_REF);
  wire go_bst = take & (cmd == CMD_BST);
  wire go_read = take & (cmd == CMD_READ) & bank_open_o[ba];
  wire go_write = take & (cmd == CMD_WRITE) & bank_open_o[ba];
  wire enter_sr = sel & ~s_cke & (cmd == CMD_REF);
  wire enter_dpd = sel & ~s_cke & (cmd == CMD_BST);
  wire [IDX_W-1:0] bl_words = BL_BASE << burst_len_i;

  function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] start,
                                                 input logic [COL_W-1:0] step,
                                                 input logic [1:0] bl_code,
                                                 input logic order);
    logic [COL_W-1:0] m;
    m = COL_W'((BL_BASE << bl_code) - 5'h1);
    burst_col = (order == ORDER_INTERLEAVED) ? ((start & ~m) | ((start ^ step) & m))
                                             : ((start & ~m) | ((start + step) & m));
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Bank state and power modes.

  logic [BANKS-1:0][ROW_W-1:0] open_row;
  logic [SR_CNT_W-1:0] sr_cnt;
  wire rd_close, wr_close;
  logic [BANK_W-1:0] rd_bank, wr_bank;
  wire [SR_CNT_W-1:0] sr_limit = s_hot ? SR_HOT_CNT : SR_PERIOD_CNT;
  wire sr_tick = (pwr == PWR_SELF_REFRESH) & (sr_cnt >= sr_limit - 8'h1);

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bank_open_o <= '0;
      open_row <= '0;
    end else begin
      for (int b = 0; b < BANKS; b++) begin
        // Each bank moves on its own, even while another bursts.
        if (enter_sr | enter_dpd) begin
          bank_open_o[b] <= 1'b0;
        end else if (go_act & (ba == b)) begin
          bank_open_o[b] <= 1'b1;
          open_row[b] <= s_addr[ROW_W-1:0];
        end else if (go_pre & (ap | (ba == b))) begin
          bank_open_o[b] <= 1'b0;
        end else if ((rd_close & (rd_bank == b)) | (wr_close & (wr_bank == b))) begin
          bank_open_o[b] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pwr <= PWR_ACTIVE;
      sr_cnt <= '0;
      refresh_pulse_o <= 1'b0;
    end else begin
      refresh_pulse_o <= go_ref | sr_tick;
      sr_cnt <= (sr_tick | (pwr != PWR_SELF_REFRESH)) ? '0 : sr_cnt + 1'b1;
      unique case (pwr)
        PWR_ACTIVE: begin
          if (enter_sr) begin
            pwr <= PWR_SELF_REFRESH;
          end else if (enter_dpd) begin
            pwr <= PWR_DEEP_DOWN;
          end
        end
        PWR_SELF_REFRESH, PWR_DEEP_DOWN: begin
          if (s_cke) begin
            pwr <= PWR_ACTIVE;
          end
        end
      endcase
    end
  end

  assign self_refresh_o = (pwr == PWR_SELF_REFRESH);
  assign deep_power_down_o = (pwr == PWR_DEEP_DOWN);

  //////////////////////////////////////////////////////////////////////////////
  // Read burst.

  rd_state_e rd_state;
  logic [1:0] rd_wait;
  logic [ROW_W-1:0] rd_row;
  logic [COL_W-1:0] rd_start;
  logic [IDX_W-1:0] rd_idx;
  logic rd_ap;
  logic [DQ_W-1:0] rd_hi;
  logic [DQ_W-1:0] mem [MEM_DEPTH];

  wire mem_addr_t rd_a0 = {rd_bank, rd_row,
                           burst_col(rd_start, rd_idx[COL_W-1:0], burst_len_i, burst_order_i)};
  wire mem_addr_t rd_a1 = {rd_bank, rd_row,
                           burst_col(rd_start, rd_idx[COL_W-1:0] + 4'h1, burst_len_i,
                                     burst_order_i)};
  wire rd_last = (rd_idx >= bl_words);
  wire rd_stop = go_write | (go_bst & ~rd_ap) | enter_sr | enter_dpd;
  wire rd_launch = rise & (((rd_state == RD_WAIT) & (rd_wait == RL2_WAIT)) |
                           ((rd_state == RD_SECOND) & ~rd_last));
  assign rd_close = rise & (rd_state == RD_SECOND) & rd_last & rd_ap & ~go_read;

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_state <= RD_IDLE;
      rd_wait <= '0;
      rd_bank <= '0;
      rd_row <= '0;
      rd_start <= '0;
      rd_idx <= '0;
      rd_ap <= 1'b0;
      rd_hi <= '0;
      dq_o <= '0;
      dq_oe_o <= 1'b0;
      dqs_o <= '0;
      dqs_oe_o <= '0;
    end else if (go_read) begin
      rd_state <= RD_WAIT;
      rd_wait <= (read_latency_i == READ_LATENCY_3) ? RL3_WAIT : RL2_WAIT;
      rd_bank <= ba;
      rd_row <= open_row[ba];
      rd_start <= s_addr[COL_W-1:0];
      rd_idx <= '0;
      rd_ap <= ap;
    end else if (rd_stop) begin
      rd_state <= RD_IDLE;
      dq_oe_o <= 1'b0;
      dqs_oe_o <= '0;
    end else if (rd_launch) begin
      rd_state <= RD_FIRST;
      dq_o <= mem[rd_a0];
      rd_hi <= mem[rd_a1];
      dq_oe_o <= 1'b1;
      dqs_o <= '1;
      dqs_oe_o <= '1;
    end else if (rise & (rd_state == RD_WAIT)) begin
      rd_wait <= rd_wait - 2'h1;
    end else if (rise & (rd_state == RD_SECOND)) begin
      rd_state <= RD_IDLE;
      dq_oe_o <= 1'b0;
      dqs_oe_o <= '0;
    end else if (fall & (rd_state == RD_FIRST)) begin
      rd_state <= RD_SECOND;
      dq_o <= rd_hi;
      dqs_o <= '0;
      rd_idx <= rd_idx + PAIR_STEP;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Write burst and array.

  logic wr_active;
  logic wr_ap;
  logic [ROW_W-1:0] wr_row;
  logic [COL_W-1:0] wr_start;
  logic [IDX_W-1:0] wr_idx;
  logic [DQ_W-1:0] wr_lo, wr_hi;
  logic [LANES-1:0] mask_lo, mask_hi;
  logic wr_commit;

  wire mem_addr_t wr_a0 = {wr_bank, wr_row,
                           burst_col(wr_start, wr_idx[COL_W-1:0], burst_len_i, burst_order_i)};
  wire mem_addr_t wr_a1 = {wr_bank, wr_row,
                           burst_col(wr_start, wr_idx[COL_W-1:0] + 4'h1, burst_len_i,
                                     burst_order_i)};
  wire wr_last = ((wr_idx + PAIR_STEP) >= bl_words);
  assign wr_close = wr_commit & wr_last & wr_ap & ~go_write;

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_active <= 1'b0;
      wr_ap <= 1'b0;
      wr_bank <= '0;
      wr_row <= '0;
      wr_start <= '0;
      wr_idx <= '0;
      wr_lo <= '0;
      wr_hi <= '0;
      mask_lo <= '1;
      mask_hi <= '1;
      wr_commit <= 1'b0;
    end else begin
      for (int l = 0; l < LANES; l++) begin
        if (lane_rise[l]) begin
          wr_lo[l*BYTE_W +: BYTE_W] <= s_dq[l*BYTE_W +: BYTE_W];
          mask_lo[l] <= s_mask[l];
        end
        if (lane_fall[l]) begin
          wr_hi[l*BYTE_W +: BYTE_W] <= s_dq[l*BYTE_W +: BYTE_W];
          mask_hi[l] <= s_mask[l];
        end
      end
      // One cycle of slack lets the other lane's falling edge land first.
      wr_commit <= lane_fall[0] & wr_active & ~go_write;
      if (go_write) begin
        wr_active <= 1'b1;
        wr_ap <= ap;
        wr_bank <= ba;
        wr_row <= open_row[ba];
        wr_start <= s_addr[COL_W-1:0];
        wr_idx <= '0;
      end else if (go_read | enter_sr | enter_dpd) begin
        wr_active <= 1'b0;
      end else if (wr_commit) begin
        wr_idx <= wr_idx + PAIR_STEP;
        if (wr_last) begin
          wr_active <= 1'b0;
        end
      end
    end
  end

  // The array holds data only, so it has no reset.
  always_ff @(posedge clock_i) begin
    if (enter_dpd) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else if (enter_sr) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        if (!partial_array_self_refresh_i[i >> (ROW_W + COL_W)]) begin
          mem[i] <= '0;
        end
      end
    end else if (wr_commit) begin
      for (int l = 0; l < LANES; l++) begin
        if (!mask_lo[l]) begin
          mem[wr_a0][l*BYTE_W +: BYTE_W] <= wr_lo[l*BYTE_W +: BYTE_W];
        end
        if (!mask_hi[l]) begin
          mem[wr_a1][l*BYTE_W +: BYTE_W] <= wr_hi[l*BYTE_W +: BYTE_W];
        end
      end
    end
  end

endmodule

// ---- sim/lpddr_core_interface_assertions.sv ----
// Pin checker for the LPDDR core interface.
// Assumes one clock domain; bound to the core below.
`timescale 1ns/10ps
module lpddr_checker (
  input wire logic clock_i, // System clock.
  input wire logic sys_rst_i, // Reset.
  input wire logic true_clock_i, // Link clock.
  input wire logic complement_clock_i, // Link clock inverse.
  input wire logic [lpddr_pkg::DQ_W-1:0] dq_o, // Read data.
  input wire logic dq_oe_o, // Data driven.
  input wire logic [lpddr_pkg::LANES-1:0] dqs_o, // Strobes.
  input wire logic [lpddr_pkg::LANES-1:0] dqs_oe_o, // Strobes driven.
  input wire logic [lpddr_pkg::BANKS-1:0] bank_open_o, // Open banks.
  input wire logic self_refresh_o, // Self refresh.
  input wire logic deep_power_down_o, // Deep power-down.
  input wire logic refresh_pulse_o // Refresh tick.
);
  import lpddr_pkg::*;
  logic link_q;
  logic [3:0] since_edge;
  // Clocks since the last rising crossing, saturating.
  wire link_rise = true_clock_i & ~complement_clock_i & ~link_q;
  wire [3:0] next_since = link_rise ? 4'h0 : since_edge + 4'(since_edge != 4'hf);
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      link_q <= 1'b0;
      since_edge <= 4'hf;
    end else begin
      link_q <= true_clock_i & ~complement_clock_i;
      since_edge <= next_since;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  oe_lanes_a: assert property (dqs_oe_o == {LANES{dq_oe_o}})
    else $error("strobe enables differ from data enable");
  strobe_lanes_a: assert property (dq_oe_o |-> dqs_o == '0 || dqs_o == '1)
    else $error("strobe lanes out of step");
  data_edge_a: assert property (dq_oe_o && $past(dq_oe_o) && dq_o != $past(dq_o)
    |-> dqs_o != $past(dqs_o)) else $error("read data moved without a strobe edge");
  first_word_a: assert property ($rose(dq_oe_o) |-> (dqs_o == '1) [*4])
    else $error("first read word not on a high strobe");
  last_half_a: assert property ($fell(dq_oe_o) |-> $past(dqs_o) == '0)
    else $error("read burst ended on a high strobe");
  act_edge_a: assert property ((bank_open_o & ~$past(bank_open_o)) != '0
    |-> since_edge <= 4'h8) else $error("bank opened away from a link edge");
  read_edge_a: assert property ($rose(dq_oe_o) |-> since_edge <= 4'h8)
    else $error("read data started away from a link edge");
  dpd_closed_a: assert property (deep_power_down_o |-> bank_open_o == '0 && !dq_oe_o)
    else $error("activity in deep power-down");
  sr_closed_a: assert property (self_refresh_o |-> bank_open_o == '0 && !deep_power_down_o)
    else $error("activity in self refresh");
  pulse_one_a: assert property (refresh_pulse_o |=> !refresh_pulse_o)
    else $error("refresh pulse longer than one cycle");
  cover property ($rose(dq_oe_o));
  cover property ($rose(deep_power_down_o));
  cover property (self_refresh_o && refresh_pulse_o);
  cover property ($fell(|bank_open_o));
endmodule
bind lpddr_core_interface lpddr_checker u_chk (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
  .true_clock_i(true_clock_i), .complement_clock_i(complement_clock_i), .dq_o(dq_o),
  .dq_oe_o(dq_oe_o), .dqs_o(dqs_o), .dqs_oe_o(dqs_oe_o), .bank_open_o(bank_open_o),
  .self_refresh_o(self_refresh_o), .deep_power_down_o(deep_power_down_o),
  .refresh_pulse_o(refresh_pulse_o));

// ---- sim/lpddr_ctrl_model.sv ----
// Controller model driving link clock, commands and write data.
// Assumes tasks are called in turn; the link clock stands still between calls.
`timescale 1ns/10ps
module lpddr_ctrl_model (
  output logic tck_o, // Link clock, true phase.
  output logic cck_o, // Link clock, complement phase.
  output logic cke_o, // Clock enable.
  output logic [3:0] cmd_o, // Select, row, column, write; low active.
  output logic [1:0] bank_o, // Bank address.
  output logic [lpddr_pkg::ADDR_W-1:0] addr_o, // Address.
  output logic [lpddr_pkg::DQ_W-1:0] dq_o, // Write data.
  output logic [lpddr_pkg::LANES-1:0] dqs_o, // Write strobes.
  output logic [lpddr_pkg::LANES-1:0] mask_o // Byte masks, high skips.
);
  import lpddr_pkg::*;
  initial begin
    {tck_o, cck_o, cke_o, cmd_o, bank_o, addr_o} = {3'h3, 4'hf, 15'h0};
    {dq_o, dqs_o, mask_o} = '0;
  end
  // One link cycle; pins settle 12 ns before the rising crossing.
  task automatic cyc(input logic [3:0] c, input logic [1:0] b, input logic [ADDR_W-1:0] a);
    {cmd_o, bank_o, addr_o} = {c, b, a};
    #12 {tck_o, cck_o} = 2'h2;
    #24 {tck_o, cck_o} = 2'h1;
    #12;
  endtask
  // Each strobe edge sits in the middle of its word.
  task automatic wcyc(input logic [31:0] w, input logic [3:0] m, input logic last);
    {cmd_o, dq_o, mask_o} = {4'hf, w[15:0], m[1:0]};
    #12 {tck_o, cck_o, dqs_o} = 4'hb;
    #12 {dq_o, mask_o} = {w[31:16], m[3:2]};
    #12 {tck_o, cck_o, dqs_o} = 4'h4;
    #12 if (last) dq_o = ~dq_o;
  endtask
  task automatic pwr(input logic v);
    cke_o = v;
  endtask
endmodule

// ---- sim/tb_top.sv ----
// Self-checking bench of the LPDDR core interface.
// Assumes the checker is bound and the model owns the link pins.
`timescale 1ns/10ps
module tb_top;
  import lpddr_pkg::*;
  localparam logic [3:0] NOP = 4'h7, ACT = 4'h3, RD = 4'h5, WR = 4'h4;
  localparam logic [3:0] BST = 4'h6, PRE = 4'h2, REF = 4'h1;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [1:0] burst_len_i = 2'h3;
  logic burst_order_i = 1'b0;
  logic read_latency_i = 1'b0;
  logic [BANKS-1:0] partial_array_self_refresh_i = 4'hf;
  logic temp_sensor_hot_i = 1'b0;
  wire true_clock_i, complement_clock_i, cke_i, dq_oe_o, self_refresh_o;
  wire deep_power_down_o, refresh_pulse_o;
  wire [3:0] cmd;
  wire [1:0] bank;
  wire [ADDR_W-1:0] addr_i;
  wire [DQ_W-1:0] dq_o, m_dq, dq_i;
  wire [LANES-1:0] dqs_o, dqs_oe_o, m_dqs, dqs_i, write_byte_mask_i;
  wire [BANKS-1:0] bank_open_o;
  logic [DQ_W-1:0] exp_mem [MEM_DEPTH];
  logic [DQ_W-1:0] rd_q [$];
  logic [LANES-1:0] dqs_last = '0;
  int n_mismatch = 0;
  int checks = 0;
  int n_ref = 0;
  time t_first;
  // Shared pins carry whichever party drives them.
  assign dq_i = dq_oe_o ? dq_o : m_dq;
  assign dqs_i = (dqs_oe_o & dqs_o) | (~dqs_oe_o & m_dqs);
  always #2.5 clock_i = ~clock_i;
  lpddr_core_interface u_dut (.clock_i, .sys_rst_i, .true_clock_i, .complement_clock_i,
    .cke_i, .cs_n_i(cmd[3]), .ras_n_i(cmd[2]), .cas_n_i(cmd[1]), .we_n_i(cmd[0]),
    .bank_select_bit0_i(bank[0]), .bank_select_bit1_i(bank[1]), .addr_i, .dq_i, .dq_o,
    .dq_oe_o, .dqs_i, .dqs_o, .dqs_oe_o, .write_byte_mask_i, .burst_len_i, .burst_order_i,
    .read_latency_i, .partial_array_self_refresh_i, .temp_sensor_hot_i, .bank_open_o,
    .self_refresh_o, .deep_power_down_o, .refresh_pulse_o);
  lpddr_ctrl_model u_ctrl (.tck_o(true_clock_i), .cck_o(complement_clock_i), .cke_o(cke_i),
    .cmd_o(cmd), .bank_o(bank), .addr_o(addr_i), .dq_o(m_dq), .dqs_o(m_dqs),
    .mask_o(write_byte_mask_i));
  // Collects one read word per strobe edge.
  always @(negedge clock_i) begin
    if (dq_oe_o === 1'b1 && dqs_o !== dqs_last) begin
      if (rd_q.size() == 0) t_first = $time;
      rd_q.push_back(dq_o);
    end
    if (refresh_pulse_o === 1'b1) n_ref++;
    dqs_last <= dqs_o;
  end
  ////////////////////////////////////////
  task automatic cmp_word(input logic [DQ_W-1:0] got, input logic [DQ_W-1:0] want);
    checks++;
    if (got !== want) begin
      n_mismatch++;
      $display("unexpected %0t data %h want %h", $time, got, want);
    end
  endtask
  task automatic cmp_stat(input logic [31:0] got, input logic [31:0] want);
    checks++;
    if (got !== want) begin
      n_mismatch++;
      $display("unexpected %0t status %h want %h", $time, got, want);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  function automatic logic [3:0] col_of(logic [3:0] s, int k, logic [1:0] bl, logic ord);
    logic [3:0] m;
    m = 4'((2 << bl) - 1);
    return (s & ~m) | ((ord ? s ^ 4'(k) : s + 4'(k)) & m);
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1.25;
  endtask
  task automatic cfg(input logic [1:0] bl, input logic ord, input logic rl);
    tick(1);
    {burst_len_i, burst_order_i, read_latency_i} = {bl, ord, rl};
  endtask
  task automatic act(input logic [1:0] b, input logic [1:0] r);
    u_ctrl.cyc(ACT, b, {11'h0, r});
  endtask
  task automatic pre_all();
    u_ctrl.cyc(PRE, 2'h0, 13'h0400);
    cmp_stat(bank_open_o, 0);
  endtask
  task automatic wr(logic [1:0] b, logic [1:0] r, logic [3:0] s, logic [1:0] bl, logic ord,
                    logic [3:0] men);
    logic [31:0] w;
    logic [3:0] m;
    int a;
    u_ctrl.cyc(WR, b, {9'h0, s});
    for (int p = 0; p < (1 << bl); p++) begin
      w = $urandom;
      m = 4'($urandom) & men;
      for (int h = 0; h < 4; h++) begin
        a = {b, r, col_of(s, 2 * p + h / 2, bl, ord)};
        if (!m[h]) exp_mem[a][8 * (h % 2) +: 8] = w[8 * h +: 8];
      end
      u_ctrl.wcyc(w, m, p == (1 << bl) - 1);
    end
    u_ctrl.cyc(NOP, 2'h0, 13'h0);
  endtask
  task automatic rd(logic [1:0] b, logic [1:0] r, logic [3:0] s, logic [1:0] bl, logic ord,
                    logic ap, logic keep);
    int hits;
    time t0;
    logic [DQ_W-1:0] e;
    hits = 0;
    rd_q.delete();
    t0 = $time + 12;
    u_ctrl.cyc(RD, b, {2'h0, ap, 6'h0, s});
    u_ctrl.cyc(ACT, b ^ 2'h1, 13'h0);
    repeat ((1 << bl) + 2) u_ctrl.cyc(NOP, 2'h0, 13'h0);
    cmp_stat(rd_q.size(), 2 << bl);
    cmp_stat((t_first - t0) / 48, read_latency_i + 1);
    for (int k = 0; k < rd_q.size(); k++) begin
      e = exp_mem[{b, r, col_of(s, k, bl, ord)}];
      hits += int'(rd_q[k] === e);
      if (keep) cmp_word(rd_q[k], e);
    end
    if (!keep) cmp_stat(hits < (2 << bl), 1);
    cmp_stat(bank_open_o, (4'h1 << (b ^ 2'h1)) | (ap ? 4'h0 : 4'h1 << b));
  endtask
  task automatic gap(output int n);
    n = 0;
    while (refresh_pulse_o !== 1'b1 && n < 500) begin
      tick(1);
      n++;
    end
    n = 0;
    do begin
      tick(1);
      n++;
    end while (refresh_pulse_o !== 1'b1 && n < 500);
  endtask
  ////////////////////////////////////////
  initial begin
    logic [1:0] b;
    logic [1:0] r;
    logic hot;
    int n;
    void'($urandom(32'hd0dd55e8));
    tick(3);
    cmp_stat({dq_oe_o, dqs_oe_o, bank_open_o, self_refresh_o, deep_power_down_o}, 0);
    tick(1);
    sys_rst_i = 1'b0;
    for (int i = 0; i < 8; i++) begin
      b = 2'($urandom);
      r = 2'($urandom);
      cfg(2'h3, 1'b0, 1'($urandom));
      act(b, r);
      wr(b, r, 4'h0, 2'h3, 1'b0, 4'h0);
      cfg(2'(i / 2), 1'(i % 2), 1'($urandom));
      wr(b, r, 4'($urandom), 2'(i / 2), 1'(i % 2), 4'hf);
      rd(b, r, 4'($urandom), 2'(i / 2), 1'(i % 2), 1'(i / 4), 1'b1);
      pre_all();
      $display("test burst %0d done", i);
    end
    cfg(2'h3, 1'b0, 1'b0);
    act(2'h2, 2'h1);
    wr(2'h2, 2'h1, 4'h0, 2'h3, 1'b0, 4'h0);
    pre_all();
    n = n_ref;
    u_ctrl.cyc(REF, 2'h0, 13'h0);
    cmp_stat(n_ref - n, 1);
    u_ctrl.pwr(1'b0);
    u_ctrl.cyc(BST, 2'h0, 13'h0);
    tick(6);
    cmp_stat({deep_power_down_o, self_refresh_o, bank_open_o}, 6'h20);
    u_ctrl.pwr(1'b1);
    tick(6);
    cmp_stat(deep_power_down_o, 0);
    act(2'h2, 2'h1);
    rd(2'h2, 2'h1, 4'h0, 2'h3, 1'b0, 1'b0, 1'b0);
    pre_all();
    $display("test deep power-down done");
    hot = 1'($urandom);
    for (int k = 0; k < 2; k++) begin
      act(2'(k), 2'h0);
      wr(2'(k), 2'h0, 4'h0, 2'h3, 1'b0, 4'h0);
    end
    u_ctrl.cyc(PRE, 2'h1, 13'h0);
    cmp_stat(bank_open_o, 4'h1);
    pre_all();
    tick(1);
    {partial_array_self_refresh_i, temp_sensor_hot_i} = {4'h1, hot};
    u_ctrl.pwr(1'b0);
    u_ctrl.cyc(REF, 2'h0, 13'h0);
    gap(n);
    gap(n);
    cmp_stat(self_refresh_o, 1);
    cmp_stat(n, hot ? SR_HOT_CNT : SR_PERIOD_CNT);
    temp_sensor_hot_i = ~hot;
    gap(n);
    gap(n);
    cmp_stat(n, hot ? SR_PERIOD_CNT : SR_HOT_CNT);
    u_ctrl.pwr(1'b1);
    tick(6);
    cmp_stat(self_refresh_o, 0);
    for (int k = 0; k < 2; k++) begin
      act(2'(k), 2'h0);
      rd(2'(k), 2'h0, 4'h0, 2'h3, 1'b0, 1'b0, 1'(k == 0));
      pre_all();
    end
    $display("test self refresh done");
    conclude();
  end
  initial begin
    #200000;
    n_mismatch++;
    $display("unexpected %0t watchdog expired", $time);
    conclude();
  end
endmodule
